// ===== shared/rcinit_cfg.svh
// Offsets, reset values and load patterns for reset-cause init
`ifndef RCINIT_CFG_SVH
`define RCINIT_CFG_SVH

// ==========================================================
// Register offsets
`define RCI_ADDR_POWER_CONTROL_STATUS      9'h08e
`define RCI_ADDR_SSP       9'h093
`define RCI_ADDR_IRQ_STS   9'h0a0
`define RCI_ADDR_IRQ_MSK   9'h0a1
`define RCI_ADDR_CAUSE     9'h0a2

// ==========================================================
// Reset values and fixed codes
`define RCI_POWER_CONTROL_STATUS_RST       4'h4
`define RCI_POWER_CONTROL_STATUS_IMPL      4'hf
`define RCI_SERIAL_SLAVE_ADDRESS_COLD    8'h00
`define RCI_SERIAL_SLAVE_ADDRESS_WARM    8'hff
`define RCI_SERIAL_ADDRESS_MASK_RST     8'hff
`define RCI_SSP_MASK_MODE  4'h9
`define RCI_PC_ZERO        13'h0000
`define RCI_PC_ONE         13'h0001
`define RCI_IRQ_VECTOR     13'h0004
`define RCI_IRQ_BIT0_OFF   8'hfe

// ==========================================================
// Status and power control patterns: new = (old & AND) | OR
`define RCI_ST_AND_POR     8'h07
`define RCI_ST_OR_POR      8'h18
`define RCI_PC_AND_POR     4'h1
`define RCI_PC_OR_POR      4'h4
`define RCI_ST_AND_MRUN    8'h1f
`define RCI_ST_OR_MRUN     8'h00
`define RCI_ST_AND_MSLP    8'h07
`define RCI_ST_OR_MSLP     8'h10
`define RCI_ST_AND_WRST    8'h0f
`define RCI_ST_OR_WRST     8'h00
`define RCI_PC_AND_WARM    4'h7
`define RCI_PC_OR_WARM     4'h0
`define RCI_ST_AND_WWAKE   8'he7
`define RCI_ST_OR_WWAKE    8'h00
`define RCI_ST_AND_BOR     8'h07
`define RCI_ST_OR_BOR      8'h18
`define RCI_PC_AND_BOR     4'h2
`define RCI_PC_OR_BOR      4'h4
`define RCI_ST_AND_IWAKE   8'he7
`define RCI_ST_OR_IWAKE    8'h10
`define RCI_PC_AND_KEEP    4'hf
`define RCI_PC_OR_KEEP     4'h0

`endif

// ===== shared/rcinit_pkg.sv
// Types shared by the reset-cause init block
package rcinit_pkg;

  // ==========================================================
  // Recorded cause of the last reset or wake-up
  typedef enum logic [2:0] {
    RCI_NONE       = 3'h0,
    RCI_POR        = 3'h1,
    RCI_EXTERNAL_RESET_PIN_RUN   = 3'h2,
    RCI_EXTERNAL_RESET_PIN_SLEEP = 3'h3,
    RCI_WDT_RST    = 3'h4,
    RCI_WDT_WAKE   = 3'h5,
    RCI_BOR        = 3'h6,
    RCI_IRQ_WAKE   = 3'h7
  } rcinit_cause_t;

  // Vector redirect sequencer, Gray coded
  typedef enum logic [1:0] {
    RCI_ST_IDLE = 2'b00,
    RCI_ST_VEC  = 2'b01
  } rcinit_fsm_t;

  // All state of the top module
  typedef struct packed {
    logic [3:0]    power_control_status;
    logic [7:0]    ssp_addr;
    logic [7:0]    ssp_mask;
    logic [7:0]    irq_sts;
    logic [7:0]    irq_msk;
    rcinit_cause_t last_cause;
    rcinit_fsm_t   fsm;
    logic [7:0]    rdata;
    logic          pc_load;
    logic [12:0]   pc_value;
    logic          st_load;
    logic [7:0]    st_value;
    logic          pin_prev;
  } rcinit_state_t;

endpackage

// ===== src/rcinit_sync.sv
// Two-stage synchroniser for the external reset pin
`timescale 1ns/1ps
`default_nettype none

module rcinit_sync (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  // ==========================================================
  // Capture; the first stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== src/rcinit_cause.sv
// Priority encoder that turns detector events into one reset cause
`timescale 1ns/1ps
`default_nettype none

module rcinit_cause
  import rcinit_pkg::*;
(
  input  wire logic    por_det_in,
  input  wire logic    bor_det_in,
  input  wire logic    pin_reset_in,
  input  wire logic    wdt_timeout_in,
  input  wire logic    irq_wake_in,
  input  wire logic    sleeping_in,
  output rcinit_cause_t cause_out
);

  // ==========================================================
  // Deep supply loss outranks brown-out, which outranks the pin
  always_comb begin
    cause_out = RCI_NONE;
    if (por_det_in) begin
      cause_out = RCI_POR;
    end else if (bor_det_in) begin
      cause_out = RCI_BOR;
    end else if (pin_reset_in) begin
      cause_out = sleeping_in ? RCI_EXTERNAL_RESET_PIN_SLEEP : RCI_EXTERNAL_RESET_PIN_RUN;
    end else if (wdt_timeout_in) begin
      cause_out = sleeping_in ? RCI_WDT_WAKE : RCI_WDT_RST;
    end else if (irq_wake_in && sleeping_in) begin
      cause_out = RCI_IRQ_WAKE; // Only a sleeping core can be woken
    end
  end

endmodule
`default_nettype wire

// ===== src/rcinit_top.sv
// Reset-cause dependent loading of program counter, status and power control
//
// How it works
// - A power-on reset loads PC 000h, status 0001 1xxx and power control 010x.
// - A pin reset while running clears PC, the top three status bits and power control bit 3.
// - A pin reset in sleep clears PC, sets status to 0001 0uuu and clears power control bit 3.
// - An interrupt wake loads PC+1, sets status bits 4:3 to 10 and leaves power control alone.
// - With the global enable set, an interrupt wake later loads the vector 0004h after one step.
// - Power control bit 0 is cleared by brown-out only and kept by every other cause.
// - The address mask shares offset 93h and is reached only while the mode field is 1001.
// - Unimplemented bits always read as zero.
// - A power-on event outranks brown-out and pin resets arriving with it.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rcinit_cfg.svh"

module rcinit_top
  import rcinit_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        por_det_in,
  input  wire logic        bor_det_in,
  input  wire logic        external_reset_pin_n_in,
  input  wire logic        watchdog_timer_timeout_in,
  input  wire logic        irq_wake_in,
  input  wire logic        sleeping_in,
  input  wire logic        global_irq_enable_in,
  input  wire logic        instr_done_in,
  input  wire logic [12:0] pc_in,
  input  wire logic [7:0]  status_in,
  input  wire logic [3:0]  serial_port_mode_field_in,
  input  wire logic [8:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [7:0]       rdata_out,
  output logic             pc_load_out,
  output logic [12:0]      pc_value_out,
  output logic             status_load_out,
  output logic [7:0]       status_value_out,
  output logic [3:0]       power_control_status_out,
  output logic [7:0]       serial_slave_address_out,
  output logic [7:0]       serial_address_mask_out,
  output logic             irq_out
);

  rcinit_state_t r;
  rcinit_state_t next_r;
  rcinit_cause_t cause;
  logic          pin_sync;
  logic          pin_fall;
  logic          mask_sel;
  logic [7:0]    st_and;
  logic [7:0]    st_or;
  logic [3:0]    pc_and;
  logic [3:0]    pc_or;

  // ==========================================================
  // Pin synchroniser and cause encoder
  rcinit_sync rcinit_sync_inst (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (external_reset_pin_n_in),
    .sync_out (pin_sync)
  );

  // Pin reset is taken on the falling edge of the synchronised level
  assign pin_fall = r.pin_prev & ~pin_sync;

  rcinit_cause rcinit_cause_inst (
    .por_det_in     (por_det_in),
    .bor_det_in     (bor_det_in),
    .pin_reset_in   (pin_fall),
    .wdt_timeout_in (watchdog_timer_timeout_in),
    .irq_wake_in    (irq_wake_in),
    .sleeping_in    (sleeping_in),
    .cause_out      (cause)
  );

  // ==========================================================
  // Pattern table, one set per cause
  always_comb begin
    st_and = 8'hff;
    st_or  = 8'h00;
    pc_and = `RCI_PC_AND_KEEP;
    pc_or  = `RCI_PC_OR_KEEP;
    case (cause)
      RCI_POR: begin
        st_and = `RCI_ST_AND_POR;
        st_or  = `RCI_ST_OR_POR;
        pc_and = `RCI_PC_AND_POR;
        pc_or  = `RCI_PC_OR_POR;
      end
      RCI_EXTERNAL_RESET_PIN_RUN: begin
        st_and = `RCI_ST_AND_MRUN;
        st_or  = `RCI_ST_OR_MRUN;
        pc_and = `RCI_PC_AND_WARM;
        pc_or  = `RCI_PC_OR_WARM;
      end
      RCI_EXTERNAL_RESET_PIN_SLEEP: begin
        st_and = `RCI_ST_AND_MSLP;
        st_or  = `RCI_ST_OR_MSLP;
        pc_and = `RCI_PC_AND_WARM;
        pc_or  = `RCI_PC_OR_WARM;
      end
      RCI_WDT_RST: begin
        st_and = `RCI_ST_AND_WRST;
        st_or  = `RCI_ST_OR_WRST;
        pc_and = `RCI_PC_AND_WARM;
        pc_or  = `RCI_PC_OR_WARM;
      end
      RCI_WDT_WAKE: begin
        st_and = `RCI_ST_AND_WWAKE;
        st_or  = `RCI_ST_OR_WWAKE;
      end
      RCI_BOR: begin
        st_and = `RCI_ST_AND_BOR;
        st_or  = `RCI_ST_OR_BOR;
        pc_and = `RCI_PC_AND_BOR;
        pc_or  = `RCI_PC_OR_BOR;
      end
      RCI_IRQ_WAKE: begin
        st_and = `RCI_ST_AND_IWAKE;
        st_or  = `RCI_ST_OR_IWAKE;
      end
      default: begin
        st_and = 8'hff;
      end
    endcase
  end

  // Mask shares its offset with the slave address
  assign mask_sel = (serial_port_mode_field_in == `RCI_SSP_MASK_MODE);

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r          = r;
    next_r.pin_prev = pin_sync;
    next_r.pc_load  = 1'b0;
    next_r.st_load  = 1'b0;
    next_r.rdata    = 8'h00;

    // Software writes; a hardware set below still wins over a clear
    if (wr_in) begin
      if (addr_in == `RCI_ADDR_POWER_CONTROL_STATUS) begin
        next_r.power_control_status = wdata_in[3:0] & `RCI_POWER_CONTROL_STATUS_IMPL;
      end else if (addr_in == `RCI_ADDR_SSP) begin
        if (mask_sel) begin
          next_r.ssp_mask = wdata_in;
        end else begin
          next_r.ssp_addr = wdata_in;
        end
      end else if (addr_in == `RCI_ADDR_IRQ_STS) begin
        next_r.irq_sts = r.irq_sts & ~wdata_in;
      end else if (addr_in == `RCI_ADDR_IRQ_MSK) begin
        next_r.irq_msk = wdata_in & `RCI_IRQ_BIT0_OFF;
      end
    end

    // Reads: unmapped offsets and unused bits answer zero
    if (rd_in) begin
      if (addr_in == `RCI_ADDR_POWER_CONTROL_STATUS) begin
        next_r.rdata = {4'h0, r.power_control_status};
      end else if (addr_in == `RCI_ADDR_SSP) begin
        next_r.rdata = mask_sel ? r.ssp_mask : r.ssp_addr;
      end else if (addr_in == `RCI_ADDR_IRQ_STS) begin
        next_r.rdata = r.irq_sts;
      end else if (addr_in == `RCI_ADDR_IRQ_MSK) begin
        next_r.rdata = r.irq_msk;
      end else if (addr_in == `RCI_ADDR_CAUSE) begin
        next_r.rdata = {5'h00, r.last_cause};
      end
    end

    // One value set per register from the recognised cause
    if (cause != RCI_NONE) begin
      next_r.last_cause = cause;
      next_r.irq_sts[cause] = 1'b1;
      next_r.st_load  = 1'b1;
      next_r.st_value = (status_in & st_and) | st_or;
      next_r.power_control_status     = (r.power_control_status & pc_and) | pc_or;
      next_r.pc_load  = 1'b1;
      next_r.fsm      = RCI_ST_IDLE;
      if (cause == RCI_WDT_WAKE || cause == RCI_IRQ_WAKE) begin
        next_r.pc_value = pc_in + `RCI_PC_ONE;
        if (cause == RCI_IRQ_WAKE && global_irq_enable_in) begin
          next_r.fsm = RCI_ST_VEC;
        end
      end else begin
        next_r.pc_value = `RCI_PC_ZERO;
        if (cause == RCI_POR) begin
          next_r.ssp_addr = `RCI_SERIAL_SLAVE_ADDRESS_COLD;
          next_r.ssp_mask = `RCI_SERIAL_ADDRESS_MASK_RST;
        end else begin
          next_r.ssp_addr = `RCI_SERIAL_SLAVE_ADDRESS_WARM;
          next_r.ssp_mask = `RCI_SERIAL_ADDRESS_MASK_RST;
        end
      end
    end else begin
      case (r.fsm)
        RCI_ST_VEC: begin
          // Vector is taken only after the woken instruction retires
          if (instr_done_in) begin
            next_r.pc_load  = 1'b1;
            next_r.pc_value = `RCI_IRQ_VECTOR;
            next_r.fsm      = RCI_ST_IDLE;
          end
        end
        default: begin
          next_r.fsm = RCI_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      r <= '{power_control_status: `RCI_POWER_CONTROL_STATUS_RST, ssp_addr: `RCI_SERIAL_SLAVE_ADDRESS_COLD,
             ssp_mask: `RCI_SERIAL_ADDRESS_MASK_RST, irq_sts: 8'h00, irq_msk: 8'h00,
             last_cause: RCI_NONE, fsm: RCI_ST_IDLE, rdata: 8'h00,
             pc_load: 1'b0, pc_value: `RCI_PC_ZERO, st_load: 1'b0,
             st_value: 8'h00, pin_prev: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out                = r.rdata;
  assign pc_load_out              = r.pc_load;
  assign pc_value_out             = r.pc_value;
  assign status_load_out          = r.st_load;
  assign status_value_out         = r.st_value;
  assign power_control_status_out = r.power_control_status;
  assign serial_slave_address_out = r.ssp_addr;
  assign serial_address_mask_out  = r.ssp_mask;
  assign irq_out                  = |(r.irq_sts & r.irq_msk);

  // ==========================================================
  // Checks
  a_por_values: assert property (@(posedge clock_in) disable iff (rst_in)
    cause == RCI_POR |=> pc_load_out && pc_value_out == 13'h0000
      && status_value_out[7:3] == 5'h03 && power_control_status_out[3:1] == 3'h2)
    else $error("power-on values wrong");

  a_pin_run: assert property (@(posedge clock_in) disable iff (rst_in)
    cause == RCI_EXTERNAL_RESET_PIN_RUN |=> pc_value_out == 13'h0000
      && status_value_out == {3'h0, $past(status_in[4:0])}
      && power_control_status_out == {1'b0, $past(r.power_control_status[2:0])})
    else $error("run pin reset values wrong");

  a_pin_sleep: assert property (@(posedge clock_in) disable iff (rst_in)
    cause == RCI_EXTERNAL_RESET_PIN_SLEEP |=> pc_value_out == 13'h0000
      && status_value_out[7:3] == 5'h02 && !power_control_status_out[3])
    else $error("sleep pin reset values wrong");

  a_irq_wake: assert property (@(posedge clock_in) disable iff (rst_in)
    cause == RCI_IRQ_WAKE |=> pc_value_out == $past(pc_in) + 13'h0001
      && status_value_out[4:3] == 2'b10 && $stable(power_control_status_out))
    else $error("interrupt wake values wrong");

  a_vector_load: assert property (@(posedge clock_in) disable iff (rst_in)
    (cause == RCI_IRQ_WAKE && global_irq_enable_in) ##1
      (instr_done_in && cause == RCI_NONE) |=> pc_load_out && pc_value_out == 13'h0004)
    else $error("vector not loaded after wake");

  a_bor_bit: assert property (@(posedge clock_in) disable iff (rst_in)
    cause != RCI_NONE && cause != RCI_BOR && cause != RCI_POR
      |=> power_control_status_out[0] == $past(r.power_control_status[0]))
    else $error("brown-out flag disturbed");

  a_mask_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_in && addr_in == 9'h093 && serial_port_mode_field_in != 4'h9
      |=> rdata_out == $past(r.ssp_addr))
    else $error("mask reachable outside mode");

  a_power_control_status_upper: assert property (@(posedge clock_in) disable iff (rst_in)
    $past(rd_in) && $past(addr_in) == 9'h08e |-> rdata_out[7:4] == 4'h0)
    else $error("unimplemented bits not zero");

  a_por_wins: assert property (@(posedge clock_in) disable iff (rst_in)
    por_det_in |-> cause == RCI_POR)
    else $error("power-on lost priority");

  a_cause_rec: assert property (@(posedge clock_in) disable iff (rst_in)
    cause != RCI_NONE |=> r.last_cause == $past(cause) && status_load_out)
    else $error("cause not recorded");

  a_wdt_wake: assert property (@(posedge clock_in) disable iff (rst_in)
    cause == RCI_WDT_WAKE |=> status_value_out[4:3] == 2'b00
      && pc_value_out == $past(pc_in) + 13'h0001)
    else $error("watchdog wake values wrong");

endmodule
`default_nettype wire

// ===== verif/tb_rcinit_top.sv
// Self-checking testbench for the reset-cause init block
`timescale 1ns/1ps
`default_nettype none

module tb_rcinit_top;

  // ==========================================================
  // Stimulus and observed signals
  logic        clock_in                  = 1'b0;
  logic        rst_in                    = 1'b1;
  logic        por_det_in                = 1'b0;
  logic        bor_det_in                = 1'b0;
  logic        external_reset_pin_n_in   = 1'b1;
  logic        watchdog_timer_timeout_in = 1'b0;
  logic        irq_wake_in               = 1'b0;
  logic        sleeping_in               = 1'b0;
  logic        global_irq_enable_in      = 1'b0;
  logic        instr_done_in             = 1'b0;
  logic [12:0] pc_in                     = 13'h0000;
  logic [7:0]  status_in                 = 8'h00;
  logic [3:0]  serial_port_mode_field_in = 4'h0;
  logic [8:0]  addr_in                   = 9'h000;
  logic [7:0]  wdata_in                  = 8'h00;
  logic        wr_in                     = 1'b0;
  logic        rd_in                     = 1'b0;
  logic [7:0]  rdata_out;
  logic        pc_load_out;
  logic [12:0] pc_value_out;
  logic        status_load_out;
  logic [7:0]  status_value_out;
  logic [3:0]  power_control_status_out;
  logic [7:0]  serial_slave_address_out;
  logic [7:0]  serial_address_mask_out;
  logic        irq_out;
  int          err_total = 0;
  int          compares  = 0;
  int          cycles    = 0;

  // One row: event kind (0 pwr-on, 1 brown-out, 2 pin, 3 watchdog, 4 irq wake) and results
  typedef struct {
    logic [2:0]  kind;
    logic        slp;
    logic [12:0] pc;
    logic [7:0]  st;
    logic [3:0]  pre;
    logic [12:0] e_pc;
    logic [7:0]  e_st;
    logic [3:0]  e_power_control_status;
    logic [2:0]  e_cause;
  } rcinit_tb_row_t;

  rcinit_tb_row_t rows [9];

  rcinit_top rcinit_top_inst (
    .clock_in                  (clock_in),
    .rst_in                    (rst_in),
    .por_det_in                (por_det_in),
    .bor_det_in                (bor_det_in),
    .external_reset_pin_n_in   (external_reset_pin_n_in),
    .watchdog_timer_timeout_in (watchdog_timer_timeout_in),
    .irq_wake_in               (irq_wake_in),
    .sleeping_in               (sleeping_in),
    .global_irq_enable_in      (global_irq_enable_in),
    .instr_done_in             (instr_done_in),
    .pc_in                     (pc_in),
    .status_in                 (status_in),
    .serial_port_mode_field_in (serial_port_mode_field_in),
    .addr_in                   (addr_in),
    .wdata_in                  (wdata_in),
    .wr_in                     (wr_in),
    .rd_in                     (rd_in),
    .rdata_out                 (rdata_out),
    .pc_load_out               (pc_load_out),
    .pc_value_out              (pc_value_out),
    .status_load_out           (status_load_out),
    .status_value_out          (status_value_out),
    .power_control_status_out  (power_control_status_out),
    .serial_slave_address_out  (serial_slave_address_out),
    .serial_address_mask_out   (serial_address_mask_out),
    .irq_out                   (irq_out)
  );

  // ==========================================================
  // Clock, 100 ns period, and a hang guard well above the expected run
  always #50 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 3000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rd(input string nm, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, rdata_out});
  endtask

  // Pulse one event; a pin event waits on the synchroniser, the rest answer next cycle
  task automatic ev(input logic [2:0] k);
    int n;
    n = 0;
    @(posedge clock_in);
    case (k)
      3'd0: por_det_in <= 1'b1;
      3'd1: bor_det_in <= 1'b1;
      3'd2: external_reset_pin_n_in <= 1'b0;
      3'd3: watchdog_timer_timeout_in <= 1'b1;
      default: irq_wake_in <= 1'b1;
    endcase
    @(posedge clock_in);
    por_det_in                <= 1'b0;
    bor_det_in                <= 1'b0;
    watchdog_timer_timeout_in <= 1'b0;
    irq_wake_in               <= 1'b0;
    #1;
    while (pc_load_out !== 1'b1 && n < 8) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    external_reset_pin_n_in <= 1'b1;
    chk("pc_load", 16'h1, {15'h0, pc_load_out});
    chk("status_load", 16'h1, {15'h0, status_load_out});
    if (k != 3'd2) begin
      chk("event latency", 16'h0, n[15:0]);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rows[0] = '{3'd0, 1'b0, 13'h0123, 8'hff, 4'hf, 13'h0000, 8'h1f, 4'h5, 3'h1};
    rows[1] = '{3'd0, 1'b0, 13'h0123, 8'h00, 4'he, 13'h0000, 8'h18, 4'h4, 3'h1};
    rows[2] = '{3'd2, 1'b0, 13'h0123, 8'hff, 4'hf, 13'h0000, 8'h1f, 4'h7, 3'h2};
    rows[3] = '{3'd2, 1'b1, 13'h0123, 8'hff, 4'hf, 13'h0000, 8'h17, 4'h7, 3'h3};
    rows[4] = '{3'd3, 1'b0, 13'h0123, 8'hff, 4'hf, 13'h0000, 8'h0f, 4'h7, 3'h4};
    rows[5] = '{3'd3, 1'b1, 13'h0123, 8'hff, 4'hf, 13'h0124, 8'he7, 4'hf, 3'h5};
    rows[6] = '{3'd1, 1'b0, 13'h0123, 8'hff, 4'hf, 13'h0000, 8'h1f, 4'h6, 3'h6};
    rows[7] = '{3'd1, 1'b0, 13'h0123, 8'h00, 4'h8, 13'h0000, 8'h18, 4'h4, 3'h6};
    rows[8] = '{3'd4, 1'b1, 13'h00ff, 8'hff, 4'ha, 13'h0100, 8'hf7, 4'ha, 3'h7};
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    // Reset values and the shared offset
    rd("power_control_status reset", 9'h08e, 8'h04);
    rd("slave addr", 9'h093, 8'h00);
    serial_port_mode_field_in <= 4'h9;
    rd("mask reset", 9'h093, 8'hff);
    serial_port_mode_field_in <= 4'h0;
    rd("unmapped", 9'h1ff, 8'h00);
    chk("irq idle", 16'h0, {15'h0, irq_out});
    // Ordinary causes from the table
    foreach (rows[i]) begin
      wr(9'h08e, {4'h0, rows[i].pre});
      sleeping_in <= rows[i].slp;
      pc_in       <= rows[i].pc;
      status_in   <= rows[i].st;
      ev(rows[i].kind);
      chk("pc value", {3'h0, rows[i].e_pc}, {3'h0, pc_value_out});
      chk("status", {8'h0, rows[i].e_st}, {8'h0, status_value_out});
      chk("power_control_status", {12'h0, rows[i].e_power_control_status}, {12'h0, power_control_status_out});
      rd("power_control_status read", 9'h08e, {4'h0, rows[i].e_power_control_status});
      rd("cause", 9'h0a2, {5'h00, rows[i].e_cause});
    end
    sleeping_in <= 1'b0;
    // Power-on and brown-out in one cycle: power-on values win
    wr(9'h08e, 8'h0f);
    status_in <= 8'hff;
    @(posedge clock_in);
    por_det_in <= 1'b1;
    bor_det_in <= 1'b1;
    @(posedge clock_in);
    por_det_in <= 1'b0;
    bor_det_in <= 1'b0;
    #1;
    chk("por over bor power_control_status", 16'h5, {12'h0, power_control_status_out});
    chk("por over bor status", 16'h1f, {8'h0, status_value_out});
    rd("por over bor cause", 9'h0a2, 8'h01);
    // Wake with global enable: next instruction, then the vector
    global_irq_enable_in <= 1'b1;
    sleeping_in          <= 1'b1;
    pc_in                <= 13'h0010;
    ev(3'd4);
    chk("wake pc", 16'h0011, {3'h0, pc_value_out});
    // The woken instruction retires in the very next cycle
    instr_done_in <= 1'b1;
    @(posedge clock_in);
    instr_done_in <= 1'b0;
    #1;
    chk("vector load", 16'h1, {15'h0, pc_load_out});
    chk("vector pc", 16'h0004, {3'h0, pc_value_out});
    global_irq_enable_in <= 1'b0;
    // Wake request while awake must be ignored
    sleeping_in <= 1'b0;
    @(posedge clock_in);
    irq_wake_in <= 1'b1;
    @(posedge clock_in);
    irq_wake_in <= 1'b0;
    #1;
    chk("awake wake ignored", 16'h0, {15'h0, pc_load_out});
    // Slave address and mask share one offset, chosen by the mode field
    ev(3'd1);
    chk("slave warm", 16'hff, {8'h0, serial_slave_address_out});
    chk("mask warm", 16'hff, {8'h0, serial_address_mask_out});
    wr(9'h093, 8'h3c);
    serial_port_mode_field_in <= 4'h9;
    wr(9'h093, 8'h5a);
    #1;
    chk("slave addr out", 16'h3c, {8'h0, serial_slave_address_out});
    chk("mask out", 16'h5a, {8'h0, serial_address_mask_out});
    rd("mask read", 9'h093, 8'h5a);
    serial_port_mode_field_in <= 4'h0;
    rd("slave read", 9'h093, 8'h3c);
    // Sticky status, mask and level output
    wr(9'h0a0, 8'hff);
    rd("sts cleared", 9'h0a0, 8'h00);
    wr(9'h0a1, 8'h40);
    ev(3'd1);
    repeat (2) @(posedge clock_in);
    #1;
    chk("irq raised", 16'h1, {15'h0, irq_out});
    wr(9'h0a1, 8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    chk("irq masked", 16'h0, {15'h0, irq_out});
    wr(9'h0a1, 8'h40);
    wr(9'h0a0, 8'h40);
    repeat (2) @(posedge clock_in);
    #1;
    chk("irq cleared", 16'h0, {15'h0, irq_out});
    rd("sts after clear", 9'h0a0, 8'h00);
    // Upper power control bits read zero even after writing ones
    wr(9'h08e, 8'hff);
    rd("power_control_status upper", 9'h08e, 8'h0f);
    // Reset in mid-run brings the registers back to their reset values
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd("power_control_status after reset", 9'h08e, 8'h04);
    rd("cause after reset", 9'h0a2, 8'h00);
    chk("irq after reset", 16'h0, {15'h0, irq_out});
    wrap_up();
  end

endmodule

`default_nettype wire
